/* File: dcs_adc_seq.sv */
`timescale 1ns/1ps
// Summary of operation
// R1: track selected input for first three clocks
// R2: hold and convert for next thirteen clocks
// R3: result MSB first, starting fifth clock
// R4: frame spans select low, sixteen-edge multiples
// R5: output enabled only while select low
// R6: power down when deselected or between slots
// R7: retrack after slot end, hold at edge four
// R8: select fall counts as first fall
// R9: clock parked high waits for real fall
// R10: shift in eight control bits per slot
// R11: control word picks next conversion's input
// R12: after reset first result from input_a
// R13: bits five to three form channel code
// R14: other control bits are ignored
// R15: low code bit chooses input_a or input_b
// R16: host never sets middle code bit
// R17: straight binary result, one step per code
// R18: back to back sixteen-clock conversions
// R19: non-result cycles drive zero
// R20: latch code at bit eight, apply next track
module dcs_adc_seq
  import dcs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial pins from the host
  input wire logic frameSelectN,
  input wire logic serialClock,
  input wire logic selectIn,
  // serial result pin, data and drive enable
  output logic resultOut,
  output logic resultOutEn,
  // digitised levels of the two inputs
  input wire logic [RESULT_W-1:0] inputA,
  input wire logic [RESULT_W-1:0] inputB,
  // status
  output logic trackMode,
  output logic powerDown,
  output logic activeChan,
  output logic [CTRL_W-1:0] nextChannelSelect,
  output logic [RESULT_W-1:0] lastResult
);

  // synchronised pins
  logic [SYNC_W-1:0] pinSync; // second-stage copies
  logic csN; // frame select, active low
  logic sclk; // serial clock level
  logic din; // control data level
  logic csPrev; // last frame select level
  logic sclkPrev; // last serial clock level

  // edge events
  logic frameOn; // frame in progress
  logic csFallEv; // frame select fell
  logic fallEv; // internal serial clock falling edge
  logic riseEv; // internal serial clock rising edge

  // counters and state
  logic [EDGE_W-1:0] fallCount; // falling edges in slot
  logic [EDGE_W-1:0] next_fallCount; // value after this edge
  logic [EDGE_W-1:0] riseCount; // rising edges in slot
  dcs_state_t state; // sequencer state
  dcs_state_t next_state; // sequencer state next cycle

  // control path
  logic [CTRL_W-1:0] ctrlShift; // control bits being shifted in
  logic [CTRL_W-1:0] ctrlWord; // complete word on eighth bit
  logic pendingChan; // channel for the next slot

  // conversion path
  logic [RESULT_W-1:0] heldValue; // sample captured at hold
  logic sarStart; // begin a new approximation
  logic sarStep; // decide one result bit
  logic sarBit; // decision of this step
  logic [RESULT_W-1:0] sarWord; // bits decided so far

  // pin synchroniser
  dcs_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .asyncIn({selectIn, serialClock, frameSelectN}),
    .syncOut(pinSync)
  );

  assign csN = pinSync[SYNC_CS];
  assign sclk = pinSync[SYNC_SCLK];
  assign din = pinSync[SYNC_DIN];

  // previous levels for edge detection
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      csPrev <= 1'b1;
      sclkPrev <= 1'b0;
    end else begin
      csPrev <= csN;
      sclkPrev <= sclk;
    end
  end

  // clock is gated off while deselected
  assign frameOn = !csN; // see R4
  assign csFallEv = csPrev && !csN;
  // select fall with clock low is the first falling edge
  assign fallEv = frameOn &&
    ((sclkPrev && !sclk) || (csFallEv && !sclk)); // see R8, R9
  // rises only count once the slot has started
  assign riseEv = frameOn && !sclkPrev && sclk && (fallCount != EDGE_NONE);

  // falling edge number after this edge, wrapping every sixteen
  always_comb begin
    next_fallCount = fallCount;
    if (fallEv) begin
      if (fallCount == EDGE_SLOT_END || fallCount == EDGE_NONE) begin
        next_fallCount = EDGE_FIRST; // see R18
      end else begin
        next_fallCount = fallCount + EDGE_FIRST;
      end
    end
  end

  // falling edge counter, cleared outside a frame
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fallCount <= EDGE_NONE;
    end else if (!frameOn) begin
      fallCount <= EDGE_NONE; // see R4
    end else begin
      fallCount <= next_fallCount;
    end
  end

  // rising edge counter, restarted with each slot
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      riseCount <= EDGE_NONE;
    end else if (!frameOn) begin
      riseCount <= EDGE_NONE;
    end else if (fallEv && next_fallCount == EDGE_FIRST) begin
      riseCount <= EDGE_NONE;
    end else if (riseEv) begin
      riseCount <= riseCount + EDGE_FIRST;
    end
  end

  // sequencer next state
  always_comb begin
    next_state = state;
    if (!frameOn) begin
      next_state = ST_OFF; // see R6
    end else if (fallEv) begin
      case (next_fallCount)
        // start of a slot: acquire
        EDGE_FIRST: begin
          next_state = ST_TRACK; // see R1, R7
        end
        // fourth fall: hold and convert
        EDGE_HOLD: begin
          next_state = ST_CONVERT; // see R2, R7
        end
        // sixteenth fall: sleep until next slot
        EDGE_SLOT_END: begin
          next_state = ST_IDLE; // see R6
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  // sequencer state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // status from state
  assign trackMode = (state == ST_TRACK);
  assign powerDown = (state == ST_OFF) || (state == ST_IDLE); // see R6

  // control word shift on the first eight rises of a slot
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrlShift <= RESET_CTRL;
    end else if (riseEv && riseCount < EDGE_CTRL_LAST) begin
      ctrlShift <= ctrlWord; // see R10
    end
  end

  assign ctrlWord = {ctrlShift[CTRL_W-2:0], din};

  // latch word and decode channel on the eighth bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nextChannelSelect <= RESET_CTRL;
      pendingChan <= RESET_CHAN;
    end else if (riseEv && riseCount == EDGE_CTRL_LAST - EDGE_FIRST) begin
      nextChannelSelect <= ctrlWord; // see R20
      // only the low code bit decides; high, middle and spare bits
      // do not steer anything, the host keeps middle low
      pendingChan <= ctrlWord[CODE_LO_POS]; // see R13, R14, R15, R16
    end
  end

  // apply pending channel at the start of each track phase
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      activeChan <= RESET_CHAN; // see R12
    end else if (fallEv && next_fallCount == EDGE_FIRST) begin
      activeChan <= pendingChan; // see R11, R20
    end
  end

  // capture the selected input as tracking ends
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      heldValue <= RESET_RESULT;
    end else if (fallEv && next_fallCount == EDGE_HOLD) begin
      heldValue <= (activeChan == CHAN_B) ? inputB : inputA; // see R1, R2
    end
  end

  // approximation strobes: start at hold, one step per data fall
  assign sarStart = fallEv && (next_fallCount == EDGE_HOLD);
  assign sarStep = fallEv && (next_fallCount >= EDGE_MSB) &&
    (next_fallCount <= EDGE_LSB); // see R3

  // successive approximation engine
  dcs_sar u_sar (
    .clk(clk),
    .resetn(resetn),
    .start(sarStart),
    .step(sarStep),
    .heldValue(heldValue),
    .decision(sarBit),
    .partial(sarWord)
  );

  // serial output: result bits on falls five to twelve, zero elsewhere
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      resultOut <= 1'b0;
    end else if (!frameOn) begin
      resultOut <= 1'b0;
    end else if (fallEv) begin
      resultOut <= sarStep ? sarBit : 1'b0; // see R3, R17, R19
    end
  end

  // finished word, kept after the last bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lastResult <= RESET_RESULT;
    end else if (fallEv && next_fallCount == EDGE_LSB + EDGE_FIRST) begin
      lastResult <= sarWord; // see R17
    end
  end

  // select acts as output enable
  assign resultOutEn = frameOn; // see R5

  // output drive follows the select pin two clocks later
  chk_drive_follows_select: assert property (@(posedge clk) // see R5
    disable iff (!resetn) resultOutEn == !$past(frameSelectN, 2))
    else $error("output enable differs from select");

  // deselected means powered down and counters clear
  chk_off_when_deselect: assert property (@(posedge clk) // see R6
    disable iff (!resetn)
    $rose(csN) |=> powerDown && fallCount == 5'h00)
    else $error("not powered down after deselect");

  // first fall of a slot enters track
  chk_track_on_first: assert property (@(posedge clk) // see R1
    disable iff (!resetn)
    fallEv && next_fallCount == 5'h01 |=> trackMode)
    else $error("track not entered on first fall");

  // tracking lasts until the fourth fall
  chk_track_to_hold: assert property (@(posedge clk) // see R7
    disable iff (!resetn) fallEv && fallCount == 5'h03 |=>
    state == ST_CONVERT && !trackMode)
    else $error("hold not entered on fourth fall");

  // select fall with clock parked low starts the slot
  chk_select_first_fall: assert property (@(posedge clk) // see R8
    disable iff (!resetn)
    csFallEv && !sclk |=> fallCount == 5'h01)
    else $error("select fall not taken as first fall");

  // zeros outside the eight result cycles
  chk_zero_fill: assert property (@(posedge clk) // see R19
    disable iff (!resetn) frameOn && (fallCount < 5'h05 ||
    fallCount > 5'h0c) |-> resultOut == 1'b0)
    else $error("non-zero outside result cycles");

  // MSB lands on the fifth fall from the held sample
  chk_msb_first: assert property (@(posedge clk) // see R3
    disable iff (!resetn) fallEv && next_fallCount == 5'h05 |=>
    resultOut == (heldValue >= 8'h80))
    else $error("first result bit is not the MSB");

  // eighth rise latches the code for the next slot
  chk_code_latch: assert property (@(posedge clk) // see R20
    disable iff (!resetn)
    riseEv && riseCount == 5'h07 |=>
    pendingChan == nextChannelSelect[3] && riseCount == 5'h08)
    else $error("channel code not latched on eighth bit");

  // slot wraps after sixteen falls into idle power-down
  chk_slot_wrap: assert property (@(posedge clk) // see R18
    disable iff (!resetn) fallEv && fallCount == 5'h0f |=>
    fallCount == 5'h10 && powerDown)
    else $error("slot did not end on sixteenth fall");

endmodule

/* File: dcs_adc_seq_tb.sv */
`timescale 1ns/1ps
module dcs_adc_seq_tb;
  import dcs_pkg::*;
  // design pins
  logic clk, resetn, frameSelectN, serialClock, selectIn;
  logic resultOut, resultOutEn, trackMode, powerDown, activeChan;
  logic [RESULT_W-1:0] inputA, inputB, lastResult;
  logic [CTRL_W-1:0] nextChannelSelect;
  // bookkeeping
  int failCount, samplesChecked;
  int fl; // fall number seen at the sample point
  logic chan; // model: channel for the coming slot
  logic curChan; // model: channel of the running slot
  logic [7:0] expRes; // model: result of the running slot

  dcs_adc_seq uut (
    .clk(clk), .resetn(resetn), .frameSelectN(frameSelectN),
    .serialClock(serialClock), .selectIn(selectIn),
    .resultOut(resultOut), .resultOutEn(resultOutEn),
    .inputA(inputA), .inputB(inputB), .trackMode(trackMode),
    .powerDown(powerDown), .activeChan(activeChan),
    .nextChannelSelect(nextChannelSelect), .lastResult(lastResult));

  dcs_host u_host (
    .clk(clk), .frameSelectN(frameSelectN), .serialClock(serialClock),
    .selectIn(selectIn), .resultOut(resultOut),
    .resultOutEn(resultOutEn));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic finishTest();
    if (failCount == 0 && samplesChecked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // model step and checks at every fall of a slot
  always @(u_host.sampled) begin
    fl = u_host.fall;
    if (fl == 1) begin
      curChan = chan;
      expRes = curChan ? inputB : inputA;
    end
    check(8'(u_host.sampledEn), 8'h01);
    check(8'(u_host.sampledBit),
      (fl >= 5 && fl <= 12) ? 8'(expRes[12 - fl]) : 8'h00);
    check(8'(trackMode), 8'(fl <= 3));
    check(8'(powerDown), 8'(fl == 16));
    check(8'(activeChan), 8'(curChan));
    if (fl == 9) begin
      check(nextChannelSelect, u_host.curWord);
      chan = u_host.curWord[CODE_LO_POS];
    end
    if (fl == 14) begin
      check(lastResult, expRes);
    end
  end

  // one frame with fresh input levels
  task automatic frame(input int edges, input logic park);
    inputA <= 8'($urandom);
    inputB <= 8'($urandom);
    @(posedge clk);
    u_host.run_frame(edges, park);
    repeat (4) @(posedge clk);
    check(8'(resultOutEn), 8'h00);
    check(8'(powerDown), 8'h01);
  endtask

  // reset pulse and reset values
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    chan = 1'b0;
    repeat (4) @(posedge clk);
    check(nextChannelSelect, RESET_CTRL);
    check(lastResult, RESET_RESULT);
    check(8'(activeChan), 8'(CHAN_A));
  endtask

  // main sequence
  initial begin
    resetn = 1'b0;
    inputA = 8'h00;
    inputB = 8'h00;
    void'($urandom(76234));
    do_reset();
    // every legal code, ignored bits set and clear
    u_host.ctrlQ = '{8'hcf, 8'h00, 8'h28, 8'h20, 8'h08, 8'hc7};
    frame(96, 1'b1);
    // random words, middle code bit kept clear
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 3; j++) begin
        u_host.ctrlQ.push_back(8'($urandom) & 8'hef);
      end
      frame(48, i[0]);
    end
    // short frame: second word never completes
    u_host.ctrlQ = '{8'h08, 8'h00};
    frame(20, 1'b0);
    u_host.ctrlQ = '{8'h08};
    frame(16, 1'b1);
    // reset mid-run after choosing the second input
    u_host.ctrlQ = '{8'h08};
    frame(16, 1'b0);
    do_reset();
    u_host.ctrlQ = '{8'h00};
    frame(16, 1'b0);
    finishTest();
  end

  // watchdog against a hang
  initial begin
    #200000;
    failCount++;
    finishTest();
  end
endmodule

/* File: dcs_host.sv */
`timescale 1ns/1ps
module dcs_host (
  // system clock
  input wire logic clk,
  // pins toward the converter
  output logic frameSelectN,
  output logic serialClock,
  output logic selectIn,
  // result pin and its drive enable
  input wire logic resultOut,
  input wire logic resultOutEn
);
  localparam int PHASE = 8; // clk cycles per serial clock phase
  logic [7:0] ctrlQ[$]; // control words, one per slot
  logic [7:0] curWord; // word sent in the running slot
  int fall; // fall number inside the slot, 1..16
  logic sampledBit; // result bit seen before each rise
  logic sampledEn; // drive enable seen with it
  event sampled; // one sample point per fall

  // pins idle, deselected
  initial begin
    frameSelectN = 1'b1;
    serialClock = 1'b0;
    selectIn = 1'b0;
  end

  // one serial clock phase
  task automatic wait_phase();
    repeat (PHASE) @(posedge clk);
  endtask

  // one frame with the given count of rising edges
  task automatic run_frame(input int edges, input logic parkHigh);
    @(posedge clk);
    frameSelectN <= 1'b0;
    wait_phase();
    // clock resting high: first real fall starts the slot
    if (serialClock) begin
      serialClock <= 1'b0;
      wait_phase();
    end
    // whole slots unless a short frame is asked for
    for (int e = 0; e < edges; e++) begin
      fall = e % 16 + 1;
      if (fall == 1) begin
        curWord = ctrlQ.pop_front();
      end
      // control bits msb first, then filler
      selectIn <= (fall <= 8) ? curWord[8 - fall] : 1'($urandom);
      wait_phase();
      sampledBit = resultOut;
      sampledEn = resultOutEn;
      ->sampled;
      serialClock <= 1'b1;
      wait_phase();
      if (e != edges - 1) begin
        serialClock <= 1'b0;
      end
    end
    wait_phase();
    // end of frame, data line no longer shows the last bit
    frameSelectN <= 1'b1;
    selectIn <= ~selectIn;
    wait_phase();
    serialClock <= parkHigh;
  endtask
endmodule

/* File: dcs_pkg.sv */
package dcs_pkg;

  // converter word widths
  localparam int unsigned RESULT_W = 8;
  localparam int unsigned CTRL_W = 8;

  // edge counter width and edge numbers inside a sixteen-clock slot
  localparam int unsigned EDGE_W = 5;
  localparam logic [4:0] EDGE_NONE = 5'h00;
  localparam logic [4:0] EDGE_FIRST = 5'h01;
  localparam logic [4:0] EDGE_TRACK_LAST = 5'h03;
  localparam logic [4:0] EDGE_HOLD = 5'h04;
  localparam logic [4:0] EDGE_MSB = 5'h05;
  localparam logic [4:0] EDGE_LSB = 5'h0c;
  localparam logic [4:0] EDGE_CTRL_LAST = 5'h08;
  localparam logic [4:0] EDGE_SLOT_END = 5'h10;

  // channel code field inside the control word
  localparam int unsigned CODE_HI_POS = 5;
  localparam int unsigned CODE_MID_POS = 4;
  localparam int unsigned CODE_LO_POS = 3;

  // channel choices and values after reset
  localparam logic CHAN_A = 1'b0;
  localparam logic CHAN_B = 1'b1;
  localparam logic RESET_CHAN = 1'b0;
  localparam logic [7:0] RESET_CTRL = 8'h00;
  localparam logic [7:0] RESET_RESULT = 8'h00;
  localparam logic [7:0] SAR_TRIAL_INIT = 8'h80;

  // pin synchroniser: bit 0 frame select, bit 1 serial clock, bit 2 data
  localparam int unsigned SYNC_W = 3;
  localparam logic [2:0] SYNC_RESET = 3'h1;
  localparam int unsigned SYNC_CS = 0;
  localparam int unsigned SYNC_SCLK = 1;
  localparam int unsigned SYNC_DIN = 2;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_TRACK = 4'h2,
    ST_CONVERT = 4'h4,
    ST_IDLE = 4'h8
  } dcs_state_t;

endpackage

/* File: dcs_sar.sv */
`timescale 1ns/1ps
module dcs_sar
  import dcs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // sequencing strobes
  input wire logic start,
  input wire logic step,
  // held sample
  input wire logic [RESULT_W-1:0] heldValue,
  // bit decided on this step, and the word built so far
  output logic decision,
  output logic [RESULT_W-1:0] partial
);

  logic [RESULT_W-1:0] trial; // one-hot weight under test

  // compare held level against the trial code
  assign decision = (heldValue >= (partial | trial));

  // approximation register, MSB weight first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      partial <= RESET_RESULT;
      trial <= SAR_TRIAL_INIT;
    end else if (start) begin
      partial <= RESET_RESULT;
      trial <= SAR_TRIAL_INIT;
    end else if (step) begin
      if (decision) begin
        partial <= partial | trial;
      end
      trial <= trial >> 1;
    end
  end

  // a kept bit never exceeds the held level
  chk_sar_bound: assert property (@(posedge clk) // see R17
    disable iff (!resetn) step |=> (partial <= heldValue))
    else $error("approximation passed held level");

endmodule

/* File: dcs_sync.sv */
`timescale 1ns/1ps
module dcs_sync
  import dcs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // raw pins and their synchronised copies
  input wire logic [SYNC_W-1:0] asyncIn,
  output logic [SYNC_W-1:0] syncOut
);

  // two flops per pin; only the second stage is visible outside
  genvar i;
  generate
    for (i = 0; i < SYNC_W; i++) begin : g_bit
      logic stage1; // first stage, read by stage two only
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          stage1 <= SYNC_RESET[i];
          syncOut[i] <= SYNC_RESET[i];
        end else begin
          stage1 <= asyncIn[i];
          syncOut[i] <= stage1;
        end
      end
    end
  endgenerate

endmodule
